// *** crp_pkg.sv ***
package crp_pkg;
    localparam int CRP_WIDTH_DEFAULT = 32;
    localparam int CRP_ADDR_BITS     = 8;
    localparam int CRP_ADDR_HI       = 6;
    localparam int CRP_LO_BIT_W32    = 2;
    localparam int CRP_LO_BIT_W16    = 1;
    localparam int CRP_LO_BIT_W8     = 0;
    localparam int CRP_DEPTH         = 32;
    localparam logic [31:0] CRP_REG_RESET = 32'h0000_0000;

    // word index of an address for a given bus width
    function automatic logic [7:0] crp_index(input logic [7:0] addr,
                                             input int width);
        logic [7:0] idx;
        idx = 8'h00;
        if (width == 32) begin
            idx = {3'h0, addr[CRP_ADDR_HI:CRP_LO_BIT_W32]};
        end else if (width == 16) begin
            idx = {2'h0, addr[CRP_ADDR_HI:CRP_LO_BIT_W16]};
        end else begin
            idx = addr >> CRP_LO_BIT_W8;
        end
        return idx;
    endfunction
endpackage

// *** crp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface crp_if #(parameter int W = 32) (input wire logic clk);
    logic             register_request;
    logic             register_read_not_write;
    logic [W/8-1:0]   register_byte_lane_enable;
    logic [7:0]       register_address;
    logic [W-1:0]     register_write_data;
    logic             register_acknowledge;
    logic [W-1:0]     register_read_data;

    modport device (input register_request, register_read_not_write,
                    register_byte_lane_enable, register_address,
                    register_write_data,
                    output register_acknowledge, register_read_data);
    modport host (output register_request, register_read_not_write,
                  register_byte_lane_enable, register_address,
                  register_write_data,
                  input register_acknowledge, register_read_data);
endinterface
`default_nettype wire

// *** crp_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module crp_device
    import crp_pkg::*;
#(
    parameter int register_bus_width = CRP_WIDTH_DEFAULT
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    crp_if.device                              bus,
    input  wire logic [7:0]                    user_index,
    output logic      [register_bus_width-1:0] user_value
);
    localparam int NB    = register_bus_width / 8;

    localparam int IDX_W = $clog2(CRP_DEPTH);

    // one bit per lane widened to a full byte of mask

    function automatic logic [register_bus_width-1:0] lane_mask(

        input logic [NB-1:0] lanes

    );

        logic [register_bus_width-1:0] mask;

        mask = '0;

        for (int b = 0; b < NB; b++) begin

            mask[b*8 +: 8] = {8{lanes[b]}};

        end

        return mask;

    endfunction

    // enabled lanes take new bytes, the rest keep old ones

    function automatic logic [register_bus_width-1:0] merge_lanes(

        input logic [register_bus_width-1:0] old_word,

        input logic [register_bus_width-1:0] new_word,

        input logic [NB-1:0]                 lanes

    );

        logic [register_bus_width-1:0] mask;

        mask = lane_mask(lanes);

        return (old_word & ~mask) | (new_word & mask);

    endfunction

    // disabled lanes read as zero so stale bytes never leak

    function automatic logic [register_bus_width-1:0] pick_lanes(

        input logic [register_bus_width-1:0] word,

        input logic [NB-1:0]                 lanes

    );

        return word & lane_mask(lanes);

    endfunction

    // request decode

    logic                          take_write;

    logic                          take_read;

    logic [7:0]                    idx;

    logic [IDX_W-1:0]              slot;

    // register file

    logic [register_bus_width-1:0] regs_q [CRP_DEPTH];

    logic [register_bus_width-1:0] regs_d [CRP_DEPTH];

    // read return

    logic [register_bus_width-1:0] rdata_q;

    logic [register_bus_width-1:0] rdata_d;

    // user view

    logic [register_bus_width-1:0] uval_q;

    logic [register_bus_width-1:0] uval_d;

    // no wait states: every access is acknowledged in its own cycle, read data follows one edge later

    assign bus.register_acknowledge = 1'b1;

    assign bus.register_read_data   = rdata_q;

    assign user_value               = uval_q;

    always_comb begin

        idx        = crp_index(bus.register_address, register_bus_width);

        // index beyond depth wraps by truncation

        slot       = idx[IDX_W-1:0];

        take_write = bus.register_request && !bus.register_read_not_write;

        take_read  = bus.register_request && bus.register_read_not_write;

    end

    // write path

    always_comb begin

        regs_d = regs_q;

        if (take_write) begin

            regs_d[slot] = merge_lanes(regs_q[slot],

                                       bus.register_write_data,

                                       bus.register_byte_lane_enable);

        end

    end

    always_ff @(posedge clk) begin

        if (reset) begin

            for (int i = 0; i < CRP_DEPTH; i++) begin

                regs_q[i] <= CRP_REG_RESET[register_bus_width-1:0];

            end

        end else begin

            regs_q <= regs_d;

        end

    end

    // read path: data stands until the next read is taken

    always_comb begin

        rdata_d = rdata_q;

        if (take_read) begin

            rdata_d = pick_lanes(regs_q[slot],

                                 bus.register_byte_lane_enable);

        end

    end

    always_ff @(posedge clk) begin

        if (reset) begin

            rdata_q <= '0;

        end else begin

            rdata_q <= rdata_d;

        end

    end

    // view path: one cycle late, independent of the bus

    always_comb begin

        uval_d = regs_q[user_index[IDX_W-1:0]];

    end

    always_ff @(posedge clk) begin

        if (reset) begin

            uval_q <= '0;

        end else begin

            uval_q <= uval_d;

        end

    end

endmodule // crp_device
`default_nettype wire

// *** crp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module crp_host
    import crp_pkg::*;
#(
    parameter int register_bus_width = CRP_WIDTH_DEFAULT
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    crp_if.host                                bus,
    input  wire logic                          cmd_valid,
    input  wire logic                          cmd_read,
    input  wire logic [register_bus_width/8-1:0] cmd_lanes,
    input  wire logic [7:0]                    cmd_address,
    input  wire logic [register_bus_width-1:0] cmd_data,
    output logic                               rsp_valid,
    output logic      [register_bus_width-1:0] rsp_data
);
    logic                          req_q, req_d, rd_q, rd_d;
    logic [register_bus_width/8-1:0] be_q, be_d;
    logic [7:0]                    addr_q, addr_d;
    logic [register_bus_width-1:0] wd_q, wd_d, rsp_q, rsp_d;
    logic                          rv_q, rv_d, pend_q, pend_d;

    assign bus.register_request          = req_q;
    assign bus.register_read_not_write   = rd_q;
    assign bus.register_byte_lane_enable = be_q;
    assign bus.register_address          = addr_q;
    assign bus.register_write_data       = wd_q;
    assign rsp_valid = rv_q;
    assign rsp_data  = rsp_q;

    always_comb begin
        req_d = cmd_valid;
        rd_d  = cmd_valid ? cmd_read : rd_q;
        be_d  = cmd_valid ? cmd_lanes : be_q;
        addr_d = cmd_valid ? cmd_address : addr_q;
        wd_d  = cmd_valid ? cmd_data : wd_q;
        // read data appears one edge after the request is taken
        pend_d = req_q && rd_q && bus.register_acknowledge;
        rv_d   = pend_q;
        rsp_d  = pend_q ? bus.register_read_data : rsp_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            req_q <= 1'b0;
            rd_q  <= 1'b0;
            be_q  <= '0;
            addr_q <= 8'h00;
            wd_q  <= '0;
            pend_q <= 1'b0;
            rv_q  <= 1'b0;
            rsp_q <= '0;
        end else begin
            req_q <= req_d;
            rd_q  <= rd_d;
            be_q  <= be_d;
            addr_q <= addr_d;
            wd_q  <= wd_d;
            pend_q <= pend_d;
            rv_q  <= rv_d;
            rsp_q <= rsp_d;
        end
    end
endmodule // crp_host
`default_nettype wire

// *** crp_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module crp_asserts #(
    parameter int W = 32
) (
    input wire logic           clk,
    input wire logic           reset,
    input wire logic           register_request,
    input wire logic           register_read_not_write,
    input wire logic [W/8-1:0] register_byte_lane_enable,
    input wire logic [7:0]     register_address,
    input wire logic [W-1:0]   register_write_data,
    input wire logic           register_acknowledge,
    input wire logic [W-1:0]   register_read_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic rq = register_request && register_read_not_write;
    wire logic wq = register_request && !register_read_not_write;
    AST_ACK_HIGH: assert property (register_acknowledge)
        else $error("ack low");
    AST_READ_ACK: assert property (rq |=> register_acknowledge)
        else $error("no ack on read");
    AST_HOLD: assert property (!rq |=> $stable(register_read_data))
        else $error("read data moved");
    AST_RST_CLEAR: assert property (
        $fell(reset) |-> register_read_data == '0)
        else $error("read data not cleared");
    AST_LANE_LO: assert property (
        rq && !register_byte_lane_enable[0]
        |=> register_read_data[7:0] == 8'h00) else $error("lane 0");
    AST_LANE_HI: assert property (
        rq && !register_byte_lane_enable[W/8-1]
        |=> register_read_data[W-1:W-8] == 8'h00) else $error("top lane");
    AST_EMPTY_BE: assert property (
        rq && register_byte_lane_enable == '0
        |=> register_read_data == '0) else $error("empty mask");
    AST_ALIAS: assert property (
        W == 32 && wq && &register_byte_lane_enable
        ##1 rq && &register_byte_lane_enable
        && register_address[6:2] == $past(register_address[6:2])
        |=> register_read_data == $past(register_write_data, 2))
        else $error("alias read");
endmodule // crp_asserts
`default_nettype wire

// *** test_crp.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_crp;
    logic        clk = 0, reset = 1, cmd_valid = 0, cmd_read = 0, rsp_valid;
    logic [3:0]  cmd_lanes = 0;
    logic [7:0]  cmd_address = 0, user_index = 0;
    logic [31:0] cmd_data = 0, rsp_data, user_value, t, mem [32], q [$];
    logic [15:0] seed = 16'h9E60;
    int          bad_count = 0, checks = 0;
    always #2.5 clk = ~clk;
    crp_if #(32) crp_if_inst (.clk(clk));
    crp_host crp_host_inst (.clk(clk), .reset(reset), .bus(crp_if_inst),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_lanes(cmd_lanes),
        .cmd_address(cmd_address), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    crp_device crp_device_inst (.clk(clk), .reset(reset), .bus(crp_if_inst),
        .user_index(user_index), .user_value(user_value));
    crp_asserts crp_asserts_inst (.clk(clk), .reset(reset),
        .register_request(crp_if_inst.register_request),
        .register_read_not_write(crp_if_inst.register_read_not_write),
        .register_byte_lane_enable(crp_if_inst.register_byte_lane_enable),
        .register_address(crp_if_inst.register_address),
        .register_write_data(crp_if_inst.register_write_data),
        .register_acknowledge(crp_if_inst.register_acknowledge),
        .register_read_data(crp_if_inst.register_read_data));
    function logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // model runs at issue time; pipeline keeps the same order
    task issue(input logic r, input logic [3:0] be, input logic [7:0] a,
               input logic [31:0] d);
        logic [31:0] m;
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_read <= r;
        cmd_lanes <= be;
        cmd_address <= a;
        cmd_data <= d;
        for (int b = 0; b < 4; b++) m[8*b +: 8] = {8{be[b]}};
        if (r) q.push_back(mem[a[6:2]] & m);
        else mem[a[6:2]] = (mem[a[6:2]] & ~m) | (d & m);
    endtask
    always @(posedge clk) begin
        if (!reset && rsp_valid) begin
            check(32'(q.size() != 0), 32'h1);
            if (q.size() != 0) check(rsp_data, q.pop_front());
        end
    end
    initial begin
        foreach (mem[i]) mem[i] = 32'h0;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            issue(1'h0, 4'hF, 8'(i * 4), {rnd(), rnd()});
            issue(1'h1, 4'hF, 8'(i * 4) ^ 8'h83, 32'h0);
        end
        for (int i = 0; i < 600; i++) begin
            t = {rnd(), rnd()};
            if (t[0]) issue(t[1], t[5:2], t[13:6], {rnd(), rnd()});
            else @(posedge clk) cmd_valid <= 1'h0;
        end
        @(posedge clk) cmd_valid <= 1'h0;
        for (int k = 0; k < 10 && q.size() != 0; k++) @(posedge clk);
        check(32'(q.size()), 32'h0);
        foreach (mem[i]) begin
            @(posedge clk) user_index <= 8'(i);
            repeat (2) @(negedge clk);
            check(user_value, mem[i]);
        end
        end_sim();
    end
endmodule // test_crp
`default_nettype wire
